// file: logic/occ_consts.svh
// Register map, field positions and timing counts of the clock source control block
`ifndef OCC_CONSTS_SVH
`define OCC_CONSTS_SVH
// ==========================================================
// Register offsets
`define OCC_CTRL_OFS      12'h000
`define OCC_STAT_OFS      12'h004
`define OCC_MASK_OFS      12'h008
// ==========================================================
// Control register fields
`define OCC_LOOP_RDY_BIT  25
`define OCC_LOOP_EN_BIT   24
`define OCC_LOOP_GATE_BIT 23
`define OCC_LOOP_BYP_BIT  22
`define OCC_SUP_EN_BIT    19
`define OCC_EXT_BYP_BIT   18
`define OCC_EXT_RDY_BIT   17
`define OCC_EXT_EN_BIT    16
`define OCC_TRIM_MSB      7
`define OCC_TRIM_LSB      3
`define OCC_INT_RDY_BIT   1
`define OCC_INT_EN_BIT    0
`define OCC_TRIM_RST      5'h10
// ==========================================================
// Event register fields and timing
`define OCC_EVT_W         4
`define OCC_EVT_LOOP      0
`define OCC_EVT_EXT       1
`define OCC_EVT_INT       2
`define OCC_EVT_FAIL      3
`define OCC_OFF_CYCLES    3'h6
`endif

// file: logic/occ_pkg.sv
// Types shared by the clock source control block
package occ_pkg;
  // Selected system clock source, from the clock switch
  typedef enum logic [1:0] {
    CLK_SRC_INT,
    CLK_SRC_EXT,
    CLK_SRC_LOOP
  } occ_clksrc_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } occ_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } occ_apb_rsp_s;

  // Analog status levels, asynchronous to clk
  typedef struct packed {
    logic loopLocked;
    logic extOscReady;
    logic intOscStable;
    logic extOscFail;
  } occ_osc_stat_s;

  typedef struct packed {
    logic       loopEnable;
    logic       loopOutputGate;
    logic       loopBypass;
    logic       extOscEnable;
    logic       extOscBypass;
    logic       intOscEnable;
    logic [4:0] intOscTrim;
    logic       supervisorRun;
  } occ_clk_ctrl_s;
endpackage : occ_pkg

// file: logic/occ_clock_source_ctrl.sv
// Clock source control register with ready flags, hardware overrides and event interrupt
`timescale 1ns/10ps
`default_nettype none
`include "occ_consts.svh"

module occ_clock_source_ctrl
  import occ_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Register bus
  input  wire occ_apb_req_s  apbReq,
  output var  occ_apb_rsp_s  apbRsp,
  // Power mode and clock switch
  input  wire logic          lowPowerEntry,
  input  wire logic          lowPowerExit,
  input  wire occ_clksrc_e   sysClkSel,
  // Oscillator status
  input  wire occ_osc_stat_s oscStat,
  // Oscillator controls and event interrupt
  output var  occ_clk_ctrl_s clkCtrl,
  output var  logic          irq
);

  // ==========================================================
  // State
  typedef struct packed {
    logic                  loopEn;
    logic                  loopGate;
    logic                  loopByp;
    logic                  supEn;
    logic                  supRun;
    logic                  extByp;
    logic                  extEn;
    logic                  intEn;
    logic [4:0]            trim;
    logic                  loopRdy;
    logic                  extRdy;
    logic                  intRdy;
    logic [2:0]            extCnt;
    logic [2:0]            intCnt;
    logic [1:0]            lockSync;
    logic [1:0]            extSync;
    logic [1:0]            intSync;
    logic [1:0]            failSync;
    logic [`OCC_EVT_W-1:0] evtStat;
    logic [`OCC_EVT_W-1:0] evtMask;
    logic                  irq;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } occ_state_s;

  localparam occ_state_s OCC_RST = '{trim: `OCC_TRIM_RST, intEn: 1'b1, default: '0};

  occ_state_s state_reg;
  occ_state_s state_next;
  logic       wrCtrl;
  logic       setup;
  logic       failEvt;
  logic [31:0] wd;

  // Hold an enable against clearing while its clock drives the system
  function automatic logic keepEn(input logic oldV, input logic newV, input logic locked);
    keepEn = locked ? (oldV | newV) : newV;
  endfunction : keepEn

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == `OCC_CTRL_OFS) || (a == `OCC_STAT_OFS) || (a == `OCC_MASK_OFS);
  endfunction : isMapped

  // Acknowledged write: the only cycle in which a write may land
  function automatic logic isWrAcc(input occ_apb_req_s r, input logic rdy);
    isWrAcc = r.psel && r.penable && rdy && r.pwrite;
  endfunction : isWrAcc

  function automatic logic [31:0] readWord(input occ_state_s s, input logic [11:0] a);
    readWord = '0;
    if (a == `OCC_CTRL_OFS) begin
      readWord[`OCC_LOOP_RDY_BIT]  = s.loopRdy;
      readWord[`OCC_LOOP_EN_BIT]   = s.loopEn;
      readWord[`OCC_LOOP_GATE_BIT] = s.loopGate;
      readWord[`OCC_LOOP_BYP_BIT]  = s.loopByp;
      readWord[`OCC_SUP_EN_BIT]    = s.supEn;
      readWord[`OCC_EXT_BYP_BIT]   = s.extByp;
      readWord[`OCC_EXT_RDY_BIT]   = s.extRdy;
      readWord[`OCC_EXT_EN_BIT]    = s.extEn;
      readWord[`OCC_TRIM_MSB:`OCC_TRIM_LSB] = s.trim;
      readWord[`OCC_INT_RDY_BIT]   = s.intRdy;
      readWord[`OCC_INT_EN_BIT]    = s.intEn;
    end else if (a == `OCC_STAT_OFS) begin
      readWord[`OCC_EVT_W-1:0] = s.evtStat;
    end else if (a == `OCC_MASK_OFS) begin
      readWord[`OCC_EVT_W-1:0] = s.evtMask;
    end
  endfunction : readWord

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    wd         = apbReq.pwdata;
    setup      = apbReq.psel && !apbReq.penable;
    wrCtrl     = isWrAcc(apbReq, state_reg.pready) &&
                 (apbReq.paddr == `OCC_CTRL_OFS);
    // Pins pass two flops before use
    state_next.lockSync = {state_reg.lockSync[0], oscStat.loopLocked};
    state_next.extSync  = {state_reg.extSync[0], oscStat.extOscReady};
    state_next.intSync  = {state_reg.intSync[0], oscStat.intOscStable};
    state_next.failSync = {state_reg.failSync[0], oscStat.extOscFail};
    failEvt = state_reg.supRun && state_reg.failSync[1];

    if (wrCtrl) begin
      state_next.loopEn = keepEn(state_reg.loopEn, wd[`OCC_LOOP_EN_BIT], sysClkSel == CLK_SRC_LOOP);
      state_next.extEn = keepEn(state_reg.extEn, wd[`OCC_EXT_EN_BIT], sysClkSel == CLK_SRC_EXT);
      state_next.intEn = keepEn(state_reg.intEn, wd[`OCC_INT_EN_BIT], sysClkSel == CLK_SRC_INT);
      state_next.loopGate = wd[`OCC_LOOP_GATE_BIT];
      state_next.loopByp  = wd[`OCC_LOOP_BYP_BIT];
      state_next.supEn    = wd[`OCC_SUP_EN_BIT];
      if (!state_reg.extEn) begin
        state_next.extByp = wd[`OCC_EXT_BYP_BIT];
      end
      state_next.trim = wd[`OCC_TRIM_MSB:`OCC_TRIM_LSB];
    end
    if (lowPowerEntry) begin
      state_next.loopEn = 1'b0;
      state_next.extEn  = 1'b0;
    end
    if (lowPowerExit || failEvt) begin
      state_next.intEn = 1'b1;
    end

    state_next.loopRdy = state_reg.loopEn && state_reg.lockSync[1];
    if (state_reg.extEn) begin
      state_next.extRdy = state_reg.extSync[1];
      state_next.extCnt = '0;
    end else if (state_reg.extCnt != '0) begin
      state_next.extCnt = state_reg.extCnt - 3'h1;
      if (state_reg.extCnt == 3'h1) begin
        state_next.extRdy = 1'b0;
      end
    end
    if (state_reg.extEn && !state_next.extEn) begin
      state_next.extCnt = `OCC_OFF_CYCLES;
    end
    if (state_reg.intEn) begin
      state_next.intRdy = state_reg.intSync[1];
      state_next.intCnt = '0;
    end else if (state_reg.intCnt != '0) begin
      state_next.intCnt = state_reg.intCnt - 3'h1;
      if (state_reg.intCnt == 3'h1) begin
        state_next.intRdy = 1'b0;
      end
    end
    if (state_reg.intEn && !state_next.intEn) begin
      state_next.intCnt = `OCC_OFF_CYCLES;
    end
    state_next.supRun = state_next.supEn && state_next.extRdy;

    // ==========================================================
    // Events: set wins over write-one clear
    if (isWrAcc(apbReq, state_reg.pready)) begin
      if (apbReq.paddr == `OCC_STAT_OFS) begin
        state_next.evtStat = state_reg.evtStat & ~wd[`OCC_EVT_W-1:0];
      end
      if (apbReq.paddr == `OCC_MASK_OFS) begin
        state_next.evtMask = wd[`OCC_EVT_W-1:0];
      end
    end
    state_next.evtStat[`OCC_EVT_LOOP] |= state_next.loopRdy & ~state_reg.loopRdy;
    state_next.evtStat[`OCC_EVT_EXT]  |= state_next.extRdy & ~state_reg.extRdy;
    state_next.evtStat[`OCC_EVT_INT]  |= state_next.intRdy & ~state_reg.intRdy;
    state_next.evtStat[`OCC_EVT_FAIL] |= failEvt;
    state_next.irq = |(state_next.evtStat & state_next.evtMask);

    // Zero-wait answer: ready in the access cycle
    state_next.pready  = setup;
    state_next.pslverr = setup && !isMapped(apbReq.paddr);
    state_next.prdata  = (setup && !apbReq.pwrite) ? readWord(state_reg, apbReq.paddr) : '0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= OCC_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign apbRsp.pready          = state_reg.pready;
  assign apbRsp.pslverr         = state_reg.pslverr;
  assign apbRsp.prdata          = state_reg.prdata;
  assign clkCtrl.loopEnable     = state_reg.loopEn;
  assign clkCtrl.loopOutputGate = state_reg.loopGate;
  assign clkCtrl.loopBypass     = state_reg.loopByp;
  assign clkCtrl.extOscEnable   = state_reg.extEn;
  assign clkCtrl.extOscBypass   = state_reg.extByp;
  assign clkCtrl.intOscEnable   = state_reg.intEn;
  assign clkCtrl.intOscTrim     = state_reg.trim;
  assign clkCtrl.supervisorRun  = state_reg.supRun;
  assign irq                    = state_reg.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic wrAcc;
  assign wrAcc = isWrAcc(apbReq, apbRsp.pready) &&
                 apbReq.paddr == `OCC_CTRL_OFS;

  AST_LOOP_READY: assert property (
    !clkCtrl.loopEnable |=> !state_reg.loopRdy)
    else $error("Loop ready set while loop disabled");

  AST_SW_ENABLE: assert property (
    wrAcc && apbReq.pwdata[`OCC_LOOP_EN_BIT] && apbReq.pwdata[`OCC_EXT_EN_BIT] && !lowPowerEntry
    |=> clkCtrl.loopEnable && clkCtrl.extOscEnable)
    else $error("Software enable not applied");

  AST_LP_CLEAR: assert property (
    lowPowerEntry |=> !clkCtrl.loopEnable && !clkCtrl.extOscEnable)
    else $error("Low-power entry left a source enabled");

  AST_LOOP_KEEP: assert property (
    clkCtrl.loopEnable && sysClkSel == CLK_SRC_LOOP && !lowPowerEntry |=> clkCtrl.loopEnable)
    else $error("Loop enable cleared while loop is system clock");

  AST_EXT_KEEP: assert property (
    clkCtrl.extOscEnable && sysClkSel == CLK_SRC_EXT && !lowPowerEntry |=> clkCtrl.extOscEnable)
    else $error("External enable cleared while in use");

  AST_INT_KEEP: assert property (
    clkCtrl.intOscEnable && sysClkSel == CLK_SRC_INT |=> clkCtrl.intOscEnable)
    else $error("Internal enable cleared while in use");

  AST_SUP_RUN: assert property (
    clkCtrl.supervisorRun |-> state_reg.supEn && state_reg.extRdy)
    else $error("Supervisor running without ready oscillator");

  AST_BYP_LOCK: assert property (
    clkCtrl.extOscEnable |=> $stable(clkCtrl.extOscBypass))
    else $error("External bypass changed while oscillator enabled");

  AST_EXT_OFF: assert property (
    $fell(clkCtrl.extOscEnable) && state_reg.extRdy ##1 (!clkCtrl.extOscEnable [*6])
    |-> $past(state_reg.extRdy) && !state_reg.extRdy)
    else $error("External ready not dropped after six cycles");

  AST_TRIM_RST: assert property (
    $rose(rst_n) |-> clkCtrl.intOscTrim == `OCC_TRIM_RST)
    else $error("Trim not at reset value");

  AST_INT_OFF: assert property (
    $fell(clkCtrl.intOscEnable) && state_reg.intRdy ##1 (!clkCtrl.intOscEnable [*6])
    |-> $past(state_reg.intRdy) && !state_reg.intRdy)
    else $error("Internal ready not dropped after six cycles");

  AST_INT_SET: assert property (
    lowPowerExit || failEvt |=> clkCtrl.intOscEnable)
    else $error("Internal enable not forced on");

  AST_IRQ: assert property (
    irq |-> $past(|(state_next.evtStat & state_next.evtMask)))
    else $error("Interrupt without unmasked event");

  AST_LOOP_RDY_SET: assert property (
    clkCtrl.loopEnable && state_reg.lockSync[1] |=> state_reg.loopRdy)
    else $error("Loop ready not raised on lock");

  AST_GATE_WRITE: assert property (
    wrAcc |=> clkCtrl.loopOutputGate == $past(apbReq.pwdata[`OCC_LOOP_GATE_BIT]))
    else $error("Loop output gate not written");

  AST_LOOP_BYP: assert property (
    wrAcc |=> clkCtrl.loopBypass == $past(apbReq.pwdata[`OCC_LOOP_BYP_BIT]))
    else $error("Loop bypass not written");

  AST_BYP_WRITE: assert property (
    wrAcc && !clkCtrl.extOscEnable |=> clkCtrl.extOscBypass == $past(apbReq.pwdata[`OCC_EXT_BYP_BIT]))
    else $error("External bypass not written while oscillator off");

  AST_TRIM_WRITE: assert property (
    wrAcc |=> clkCtrl.intOscTrim == $past(apbReq.pwdata[`OCC_TRIM_MSB:`OCC_TRIM_LSB]))
    else $error("Trim not written");

  AST_FAIL_EVT: assert property (
    failEvt |=> state_reg.evtStat[`OCC_EVT_FAIL])
    else $error("Failure event not recorded");

  AST_PREADY: assert property (
    apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("No answer in the access cycle");

  AST_SLVERR: assert property (
    apbRsp.pslverr |-> apbRsp.pready)
    else $error("Error response without ready");

  AST_PRDATA_IDLE: assert property (
    !apbRsp.pready |-> apbRsp.prdata == '0)
    else $error("Read data outside the access cycle");

  COV_LOOP_LOCK: cover property ($rose(state_reg.loopRdy));
  COV_FAIL: cover property (failEvt ##1 clkCtrl.intOscEnable);
  COV_REFUSED: cover property (wrAcc && !apbReq.pwdata[`OCC_LOOP_EN_BIT] &&
    sysClkSel == CLK_SRC_LOOP && clkCtrl.loopEnable);
  COV_EXT_OFF: cover property ($fell(state_reg.extRdy));
  COV_BYP_LOCK: cover property (wrAcc && clkCtrl.extOscEnable &&
    apbReq.pwdata[`OCC_EXT_BYP_BIT] != clkCtrl.extOscBypass);

endmodule : occ_clock_source_ctrl
`default_nettype wire

// file: verif/test_occ_clock_source_ctrl.sv
// Self-checking testbench of the clock source control block
`timescale 1ns/10ps
`default_nettype none
`include "occ_consts.svh"

module test_occ_clock_source_ctrl
  import occ_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic          clk;
  logic          rst_n;
  occ_apb_req_s  apbReq;
  occ_apb_rsp_s  apbRsp;
  logic          lowPowerEntry;
  logic          lowPowerExit;
  occ_clksrc_e   sysClkSel;
  occ_osc_stat_s oscStat;
  occ_clk_ctrl_s clkCtrl;
  logic          irq;
  int            errCount;
  int            checkCount;
  int            cycles;

  occ_clock_source_ctrl occ_clock_source_ctrl_inst (
    .clk           (clk),
    .rst_n         (rst_n),
    .apbReq        (apbReq),
    .apbRsp        (apbRsp),
    .lowPowerEntry (lowPowerEntry),
    .lowPowerExit  (lowPowerExit),
    .sysClkSel     (sysClkSel),
    .oscStat       (oscStat),
    .clkCtrl       (clkCtrl),
    .irq           (irq)
  );

  always #25 clk = ~clk;

  // ==========================================================
  // Shared tasks
  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : endSim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    apbReq <= '{1'h1, 1'h0, wr, a, d};
    @(posedge clk);
    apbReq.penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'h1 && n < 20);
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq <= '0;
    if (n >= 20) begin
      errCount++;
      $display("BAD %0t bus transfer never answered", $time);
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'h1, a, d, q, e);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic        e;
    apb(1'h0, a, 32'h0, q, e);
    chk(q & m, exp, what);
  endtask : rdc

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdc(`OCC_CTRL_OFS, 32'hffffffff, 32'h00000081, "ctrl reset");
    chk(32'(clkCtrl.intOscTrim), 32'(`OCC_TRIM_RST), "trim port");
    rdc(`OCC_MASK_OFS, 32'hffffffff, 32'h0, "mask reset");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_fields();
    // Read-only bits written as ones must not stick; reserved kept at zero
    wr(`OCC_CTRL_OFS, 32'h02ce005b);
    rdc(`OCC_CTRL_OFS, 32'hffffffff, 32'h00cc0059, "ctrl fields");
    chk(32'({clkCtrl.loopOutputGate, clkCtrl.loopBypass, clkCtrl.extOscBypass}), 32'h7, "ctrl ports");
    $display("t_fields done");
  endtask : t_fields

  task automatic t_bypass_lock();
    wr(`OCC_CTRL_OFS, 32'h000d0059);
    wr(`OCC_CTRL_OFS, 32'h00090059);
    rdc(`OCC_CTRL_OFS, 32'hffffffff, 32'h000d0059, "bypass locked");
    $display("t_bypass_lock done");
  endtask : t_bypass_lock

  task automatic t_ext_ready();
    int n;
    n = 0;
    oscStat.extOscReady <= 1'h1;
    while (clkCtrl.supervisorRun !== 1'h1 && n < 12) begin
      @(posedge clk);
      n++;
    end
    chk(32'(clkCtrl.supervisorRun), 32'h1, "supervisor run");
    rdc(`OCC_CTRL_OFS, 32'hffffffff, 32'h000f0059, "ext ready");
    wr(`OCC_CTRL_OFS, 32'h000c0059);
    n = 0;
    while (clkCtrl.supervisorRun === 1'h1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= 5 && n <= 8), 32'h1, "ext flag fall delay");
    rdc(`OCC_CTRL_OFS, 32'hffffffff, 32'h000c0059, "ext off");
    $display("t_ext_ready done");
  endtask : t_ext_ready

  task automatic t_int_ready();
    oscStat.intOscStable <= 1'h1;
    sysClkSel            <= CLK_SRC_EXT;
    wr(`OCC_CTRL_OFS, 32'h00010001);
    repeat (8) @(posedge clk);
    rdc(`OCC_CTRL_OFS, 32'hffffffff, 32'h00030003, "int ready");
    wr(`OCC_CTRL_OFS, 32'h00010000);
    rdc(`OCC_CTRL_OFS, 32'hffffffff, 32'h00030002, "int flag held");
    repeat (8) @(posedge clk);
    rdc(`OCC_CTRL_OFS, 32'hffffffff, 32'h00030000, "int flag gone");
    $display("t_int_ready done");
  endtask : t_int_ready

  task automatic t_protect();
    occ_clksrc_e src[3] = '{CLK_SRC_INT, CLK_SRC_EXT, CLK_SRC_LOOP};
    logic [31:0] keep[3] = '{32'h00000001, 32'h00010000, 32'h01000000};
    for (int i = 0; i < 3; i++) begin
      sysClkSel <= src[i];
      wr(`OCC_CTRL_OFS, 32'h01010001);
      wr(`OCC_CTRL_OFS, 32'h0);
      rdc(`OCC_CTRL_OFS, 32'h01010001, keep[i], "protected enable");
    end
    $display("t_protect done");
  endtask : t_protect

  task automatic t_lowpower();
    int n;
    oscStat.loopLocked <= 1'h1;
    wr(`OCC_CTRL_OFS, 32'h01010000);
    repeat (6) @(posedge clk);
    rdc(`OCC_CTRL_OFS, 32'h03000001, 32'h03000000, "loop ready");
    lowPowerEntry <= 1'h1;
    @(posedge clk);
    lowPowerEntry <= 1'h0;
    repeat (2) @(posedge clk);
    chk(32'({clkCtrl.loopEnable, clkCtrl.extOscEnable}), 32'h0, "low power entry");
    rdc(`OCC_CTRL_OFS, 32'h02000000, 32'h0, "loop ready cleared");
    lowPowerExit <= 1'h1;
    @(posedge clk);
    lowPowerExit <= 1'h0;
    repeat (2) @(posedge clk);
    chk(32'(clkCtrl.intOscEnable), 32'h1, "low power exit");
    // Supervisor must run for a failure to count
    wr(`OCC_CTRL_OFS, 32'h00090000);
    @(posedge clk);
    chk(32'(clkCtrl.intOscEnable), 32'h0, "int disabled");
    oscStat.extOscFail <= 1'h1;
    n = 0;
    while (clkCtrl.intOscEnable !== 1'h1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk(32'(clkCtrl.intOscEnable), 32'h1, "failure sets int");
    oscStat.extOscFail <= 1'h0;
    $display("t_lowpower done");
  endtask : t_lowpower

  task automatic t_irq();
    logic [31:0] q;
    logic        e;
    rdc(`OCC_STAT_OFS, 32'h2, 32'h2, "ext event");
    chk(32'(irq), 32'h0, "irq masked");
    wr(`OCC_MASK_OFS, 32'h2);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1, "irq raised");
    wr(`OCC_STAT_OFS, 32'hf);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "irq cleared");
    rdc(`OCC_STAT_OFS, 32'hffffffff, 32'h0, "status cleared");
    apb(1'h0, 12'h00c, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1, "unmapped");
    $display("t_irq done");
  endtask : t_irq

  // ==========================================================
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      $display("BAD %0t run timed out", $time);
      endSim();
    end
  end

  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    apbReq = '0;
    lowPowerEntry = 1'h0;
    lowPowerExit = 1'h0;
    sysClkSel = CLK_SRC_INT;
    oscStat = '0;
    errCount = 0;
    checkCount = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_fields();
    t_bypass_lock();
    t_ext_ready();
    t_int_ready();
    t_protect();
    t_lowpower();
    t_irq();
    endSim();
  end
endmodule : test_occ_clock_source_ctrl
`default_nettype wire
